// File: scrs_sync_check.v
// sync check elements with reclose supervision window and lockout
//
// Overview of operation
// - slipping with close time: compensated angle time-varying
// - decreasing angle crossing zero asserts both outputs
// - past zero, increasing, below limit asserts
// - window expiry without supervision gives lockout
// - zero window: single check, lockout if unasserted
// - last instant: drop zero crossing, check limit
// - last-instant assertion lasts one quarter cycle
// - first output may drive supervision, passes close
// - independent angle limits for both outputs
// - one close contact for reclose and manual
// - static or zero close time: plain limit check
// - static when slip at most 0.005 Hz
// - outputs only while slip within maximum setting
// - compensation adds slip times close time times 6 / 4000 deg
`timescale 1ns/100ps
`default_nettype none
`include "scrs_map.vh"

module scrs_sync_check #(
  parameter QTR_CLKS = `SCRS_QTR_CYCLE_CLKS
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [15:0] angle_diff,
  input  wire [15:0] slip_freq,
  input  wire        open_interval_done,
  input  wire        sup_extra,
  input  wire        manual_close_input,
  output reg         sync_ok_first,
  output reg         sync_ok_second,
  output reg         reclose_supervision_condition,
  output reg         manual_close_condition,
  output reg         close_output_contact,
  output reg         lockout,
  output reg         irq
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE   = 2'd0;
  localparam [1:0] ST_TIMING = 2'd1;
  localparam [1:0] ST_SINGLE = 2'd2;
  localparam [1:0] ST_DONE   = 2'd3;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [2:0]  ctrl;
  reg  [15:0] max_angle_first;
  reg  [15:0] max_angle_second;
  reg  [15:0] breaker_close_time;
  reg  [15:0] reclose_supervision_window;
  reg  [15:0] max_slip_setting;
  reg  [3:0]  int_stat;
  reg  [3:0]  int_mask;
  reg  [31:0] tick_cnt;
  reg         tick;
  reg  [1:0]  state;
  reg  [15:0] win_cnt;
  reg  signed [39:0] prev_ang;
  reg  [15:0] prev_abs;
  reg         prev_valid;
  reg         passed_zero;
  reg         open_prev;
  reg         slip_within_limit;
  reg         static_mode;

  wire        wr_acc = psel & penable & pwrite & pready;
  wire        rd_acc = psel & penable & ~pwrite & ~pready;

  // ----------------------------------------------------------------
  // angle compensation
  // ----------------------------------------------------------------
  wire signed [15:0] slip_s = slip_freq;
  wire signed [15:0] ang_s  = angle_diff;
  wire        [15:0] slip_abs = slip_s[15] ? (16'h0000 - slip_freq)
                                           : slip_freq;
  wire signed [32:0] prod = slip_s * $signed({1'b0, breaker_close_time});
  wire signed [39:0] prod_w = {{7{prod[32]}}, prod};
  // slip mHz x close quarter cycles x 6 deg / 4000 -> 0.01 deg units
  wire signed [39:0] comp_w = (prod_w * 40'sd3) / 40'sd20;
  wire signed [39:0] ang_w  = {{24{ang_s[15]}}, ang_s};
  wire signed [39:0] sum_w  = ang_w + comp_w;
  reg  signed [39:0] wrap_w;
  reg  signed [39:0] cur_ang;
  reg         [39:0] abs_w;
  reg         [15:0] cur_abs;
  wire        slipping = slip_abs > `SCRS_STATIC_SLIP_MHZ;
  wire        use_comp = slipping & (breaker_close_time != 16'h0000);

  always @* begin
    if (sum_w > `SCRS_HALF_TURN)
      wrap_w = sum_w - `SCRS_FULL_TURN;
    else if (sum_w < -`SCRS_HALF_TURN)
      wrap_w = sum_w + `SCRS_FULL_TURN;
    else
      wrap_w = sum_w;
    cur_ang = use_comp ? wrap_w : ang_w;
    abs_w   = cur_ang[39] ? (40'h0000000000 - cur_ang) : cur_ang;
    cur_abs = (abs_w > 40'h000000FFFF) ? 16'hFFFF : abs_w[15:0];
  end

  // ----------------------------------------------------------------
  // zero crossing and direction
  // ----------------------------------------------------------------
  wire crossing = prev_valid & (prev_ang != 40'sd0)
                & ((cur_ang == 40'sd0) | (cur_ang[39] != prev_ang[39]))
                & (prev_abs < `SCRS_QUARTER_TURN);
  wire increasing = prev_valid & (cur_abs > prev_abs);
  wire decreasing = prev_valid & (cur_abs < prev_abs);

  // ----------------------------------------------------------------
  // check element decision
  // ----------------------------------------------------------------
  wire last_instant = ((state == ST_TIMING) & (win_cnt == 16'h0001))
                    | (state == ST_SINGLE);
  wire relaxed = last_instant & ~reclose_supervision_condition;
  wire valid   = ctrl[`SCRS_CTRL_ENABLE] & slip_within_limit;
  wire below1  = cur_abs < max_angle_first;
  wire below2  = cur_abs < max_angle_second;
  wire slip_mode = ~static_mode & (breaker_close_time != 16'h0000);
  reg  next_first;
  reg  next_second;
  reg  next_sup;

  always @* begin
    if (!valid) begin
      next_first  = 1'b0;
      next_second = 1'b0;
    end else if (!slip_mode) begin
      next_first  = below1;
      next_second = below2;
    end else begin
      next_first  = crossing
                  | (passed_zero & increasing & below1)
                  | (relaxed & below1);
      next_second = crossing
                  | (passed_zero & increasing & below2)
                  | (relaxed & below2);
    end
    next_sup = (ctrl[`SCRS_CTRL_SUP_FIRST] & next_first)
             | sup_extra;
  end

  // ----------------------------------------------------------------
  // quarter-cycle processing tick
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= 32'h00000000;
      tick     <= 1'b0;
    end else if (tick_cnt >= QTR_CLKS - 1) begin
      tick_cnt <= 32'h00000000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
      tick     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // evaluation, supervision timer and lockout
  // ----------------------------------------------------------------
  wire lock_clr = wr_acc & (paddr == `SCRS_CTRL_OFS)
                & pwdata[`SCRS_CTRL_LOCK_CLR];
  wire open_rise = open_interval_done & ~open_prev;
  reg  ev_lock;
  reg  ev_close;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state                         <= ST_IDLE;
      win_cnt                       <= 16'h0000;
      prev_ang                      <= 40'sd0;
      prev_abs                      <= 16'h0000;
      prev_valid                    <= 1'b0;
      passed_zero                   <= 1'b0;
      open_prev                     <= 1'b0;
      slip_within_limit             <= 1'b0;
      static_mode                   <= 1'b1;
      sync_ok_first                 <= 1'b0;
      sync_ok_second                <= 1'b0;
      reclose_supervision_condition <= 1'b0;
      manual_close_condition        <= 1'b0;
      close_output_contact          <= 1'b0;
      lockout                       <= 1'b0;
      ev_lock                       <= 1'b0;
      ev_close                      <= 1'b0;
    end else begin
      ev_lock  <= 1'b0;
      ev_close <= 1'b0;
      if (lock_clr)
        lockout <= 1'b0;
      if (tick) begin
        slip_within_limit <= slip_abs < max_slip_setting;
        static_mode       <= ~slipping;
        prev_ang          <= cur_ang;
        prev_abs          <= cur_abs;
        prev_valid        <= valid;
        if (crossing)
          passed_zero <= 1'b1;
        else if (decreasing | ~valid)
          passed_zero <= 1'b0;
        // outputs stand one tick: a relaxed pulse is one quarter cycle
        sync_ok_first                 <= next_first;
        sync_ok_second                <= next_second;
        reclose_supervision_condition <= next_sup;
        manual_close_condition <= manual_close_input & next_second;
        open_prev <= open_interval_done;
        close_output_contact <= (manual_close_input & next_second)
                              | ((state != ST_IDLE) & (state != ST_DONE)
                                 & open_interval_done & next_sup)
                              | ((state == ST_DONE) & open_interval_done
                                 & close_output_contact);
        case (state)
          ST_IDLE: begin
            if (open_rise & ~lockout) begin
              if (reclose_supervision_window == 16'h0000)
                state <= ST_SINGLE;
              else begin
                state   <= ST_TIMING;
                win_cnt <= reclose_supervision_window;
              end
            end
          end
          ST_TIMING: begin
            if (!open_interval_done)
              state <= ST_IDLE;
            else if (next_sup) begin
              state    <= ST_DONE;
              ev_close <= 1'b1;
            end else if (win_cnt == 16'h0001) begin
              state   <= ST_IDLE;
              lockout <= 1'b1;
              ev_lock <= 1'b1;
            end else
              win_cnt <= win_cnt - 16'h0001;
          end
          ST_SINGLE: begin
            if (next_sup) begin
              state    <= ST_DONE;
              ev_close <= 1'b1;
            end else begin
              state   <= ST_IDLE;
              lockout <= 1'b1;
              ev_lock <= 1'b1;
            end
          end
          ST_DONE: begin
            if (!open_interval_done)
              state <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  reg  first_d;
  reg  second_d;
  wire [3:0] events = {ev_close, ev_lock,
                       sync_ok_second & ~second_d,
                       sync_ok_first & ~first_d};
  wire [3:0] w1c = (wr_acc & (paddr == `SCRS_INT_STAT_OFS))
                 ? pwdata[3:0] : 4'h0;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      first_d  <= 1'b0;
      second_d <= 1'b0;
      int_stat <= 4'h0;
      irq      <= 1'b0;
    end else begin
      first_d  <= sync_ok_first;
      second_d <= sync_ok_second;
      int_stat <= (int_stat & ~w1c) | events;
      irq      <= |(((int_stat & ~w1c) | events) & int_mask);
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  reg  [31:0] rd_mux;
  reg         rd_err;

  always @* begin
    rd_err = 1'b0;
    case (paddr)
      `SCRS_CTRL_OFS:       rd_mux = {29'h00000000, 1'b0, ctrl[1:0]};
      `SCRS_ANG1_OFS:       rd_mux = {16'h0000, max_angle_first};
      `SCRS_ANG2_OFS:       rd_mux = {16'h0000, max_angle_second};
      `SCRS_CLOSE_TIME_OFS: rd_mux = {16'h0000, breaker_close_time};
      `SCRS_WINDOW_OFS:     rd_mux = {16'h0000, reclose_supervision_window};
      `SCRS_MAX_SLIP_OFS:   rd_mux = {16'h0000, max_slip_setting};
      `SCRS_STATUS_OFS:     rd_mux = {22'h000000, state, static_mode,
                                      slip_within_limit, lockout,
                                      close_output_contact,
                                      reclose_supervision_condition,
                                      sync_ok_second, sync_ok_first,
                                      passed_zero};
      `SCRS_INT_STAT_OFS:   rd_mux = {28'h0000000, int_stat};
      `SCRS_INT_MASK_OFS:   rd_mux = {28'h0000000, int_mask};
      default: begin
        rd_mux = 32'h00000000;
        rd_err = 1'b1;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pready                     <= 1'b0;
      pslverr                    <= 1'b0;
      prdata                     <= 32'h00000000;
      ctrl                       <= `SCRS_CTRL_RST;
      max_angle_first            <= `SCRS_ANG1_RST;
      max_angle_second           <= `SCRS_ANG2_RST;
      breaker_close_time         <= `SCRS_CLOSE_TIME_RST;
      reclose_supervision_window <= `SCRS_WINDOW_RST;
      max_slip_setting           <= `SCRS_MAX_SLIP_RST;
      int_mask                   <= 4'h0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & rd_err;
      if (rd_acc)
        prdata <= rd_mux;
      if (wr_acc) begin
        case (paddr)
          `SCRS_CTRL_OFS:       ctrl <= {1'b0, pwdata[1:0]};
          `SCRS_ANG1_OFS:       max_angle_first <= pwdata[15:0];
          `SCRS_ANG2_OFS:       max_angle_second <= pwdata[15:0];
          `SCRS_CLOSE_TIME_OFS: breaker_close_time <= pwdata[15:0];
          `SCRS_WINDOW_OFS:     reclose_supervision_window <= pwdata[15:0];
          `SCRS_MAX_SLIP_OFS:   max_slip_setting <= pwdata[15:0];
          `SCRS_INT_MASK_OFS:   int_mask <= pwdata[3:0];
          default:              ctrl <= ctrl;
        endcase
      end
    end
  end

endmodule // scrs_sync_check

`default_nettype wire

// File: scrs_map.vh
// constants for the sync check reclose supervision block
`ifndef SCRS_MAP_VH
`define SCRS_MAP_VH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define SCRS_CTRL_OFS        8'h00
`define SCRS_ANG1_OFS        8'h04
`define SCRS_ANG2_OFS        8'h08
`define SCRS_CLOSE_TIME_OFS  8'h0C
`define SCRS_WINDOW_OFS      8'h10
`define SCRS_MAX_SLIP_OFS    8'h14
`define SCRS_STATUS_OFS      8'h18
`define SCRS_INT_STAT_OFS    8'h1C
`define SCRS_INT_MASK_OFS    8'h20

// ------------------------------------------------------------------
// control fields
// ------------------------------------------------------------------
`define SCRS_CTRL_ENABLE     0
`define SCRS_CTRL_SUP_FIRST  1
`define SCRS_CTRL_LOCK_CLR   2

// ------------------------------------------------------------------
// interrupt event bits
// ------------------------------------------------------------------
`define SCRS_EV_FIRST        0
`define SCRS_EV_SECOND       1
`define SCRS_EV_LOCKOUT      2
`define SCRS_EV_CLOSE        3

// ------------------------------------------------------------------
// reset values (angles in 0.01 deg, times in quarter cycles, slip mHz)
// ------------------------------------------------------------------
`define SCRS_CTRL_RST        3'h3
`define SCRS_ANG1_RST        16'h05DC
`define SCRS_ANG2_RST        16'h09C4
`define SCRS_CLOSE_TIME_RST  16'h0000
`define SCRS_WINDOW_RST      16'h00F0
`define SCRS_MAX_SLIP_RST    16'h0064

// ------------------------------------------------------------------
// timing and thresholds
// ------------------------------------------------------------------
`define SCRS_CLK_PERIOD_NS   10
`define SCRS_QTR_CYCLE_NS    4166667
`define SCRS_QTR_CYCLE_CLKS  (`SCRS_QTR_CYCLE_NS / `SCRS_CLK_PERIOD_NS)
`define SCRS_STATIC_SLIP_MHZ 16'h0005
`define SCRS_HALF_TURN       40'sd18000
`define SCRS_FULL_TURN       40'sd36000
`define SCRS_QUARTER_TURN    16'h2328

`endif

// File: scrs_checker.sv
// port assertions for the sync check reclose supervision block
`timescale 1ns/100ps
`default_nettype none
module scrs_checker #(
  parameter QTR_CLKS = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwrite,
  input wire logic sup_extra,
  input wire logic manual_close_input,
  input wire logic sync_ok_first,
  input wire logic sync_ok_second,
  input wire logic reclose_supervision_condition,
  input wire logic manual_close_condition,
  input wire logic close_output_contact,
  input wire logic lockout
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  int since;
  // ----
  // cycles since a check output last changed
  // ----
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      since <= QTR_CLKS;
    end else if ($changed(sync_ok_first) || $changed(sync_ok_second)) begin
      since <= 0;
    end else begin
      since <= since + 1;
    end
  end
  chk_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer not after one wait state");
  chk_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access phase");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_output_spacing: assert property (
    ($changed(sync_ok_first) || $changed(sync_ok_second))
      |-> since >= QTR_CLKS - 1)
    else $error("check output changed inside a quarter period");
  chk_first_hold: assert property (
    $rose(sync_ok_first) |=> sync_ok_first [*7])
    else $error("first check output shorter than a quarter");
  chk_lock_sticky: assert property (
    lockout && !(pready && pwrite) |=> lockout)
    else $error("lockout left without a clear write");
  chk_lock_cause: assert property (
    $rose(lockout) |-> !reclose_supervision_condition && !close_output_contact)
    else $error("lockout with supervision asserted");
  chk_sup_cause: assert property (
    reclose_supervision_condition |-> $past(sup_extra) || sync_ok_first
      || $past(sync_ok_first))
    else $error("supervision without a cause");
  chk_close_cause: assert property (
    $rose(close_output_contact) |-> reclose_supervision_condition
      || $past(reclose_supervision_condition)
      || $past(reclose_supervision_condition, 2) || manual_close_condition
      || ($past(manual_close_input) && sync_ok_second))
    else $error("close without reclose or manual cause");
  chk_manual_cause: assert property (
    manual_close_condition |-> $past(manual_close_input)
      && (sync_ok_second || $past(sync_ok_second)))
    else $error("manual close condition without request");
  cov_lockout: cover property ($rose(lockout));
  cov_close: cover property ($rose(close_output_contact));
  cov_second_only: cover property ($rose(sync_ok_second) && !sync_ok_first);
endmodule // scrs_checker

bind scrs_sync_check scrs_checker #(.QTR_CLKS(QTR_CLKS)) i_chk (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .pwrite(pwrite), .sup_extra(sup_extra),
  .manual_close_input(manual_close_input), .sync_ok_first(sync_ok_first),
  .sync_ok_second(sync_ok_second),
  .reclose_supervision_condition(reclose_supervision_condition),
  .manual_close_condition(manual_close_condition),
  .close_output_contact(close_output_contact), .lockout(lockout)
);
`default_nettype wire

// File: scrs_reclose_model.sv
// reclose logic model holding the sealed-in open interval
`timescale 1ns/100ps
`default_nettype none
module scrs_reclose_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic close_output_contact,
  input  wire logic lockout,
  output logic      open_interval_done,
  output logic      sup_extra
);
  // ----
  // sealed in until close issued or lockout
  // ----
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      open_interval_done <= 1'b0;
    end else if (close_output_contact || lockout) begin
      open_interval_done <= 1'b0;
    end else if (start) begin
      open_interval_done <= 1'b1;
    end
  end
  assign sup_extra = 1'b0;
endmodule // scrs_reclose_model
`default_nettype wire

// File: scrs_sync_check_tb.sv
// testbench for the sync check reclose supervision block
`timescale 1ns/100ps
`default_nettype none
module scrs_sync_check_tb;
  localparam int QTR = 8;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] angle_diff = 16'h0000;
  logic [15:0] slip_freq = 16'h0005;
  logic        manual_close_input = 1'b0;
  logic        start = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, open_interval_done, sup_extra, irq;
  wire         sync_ok_first, sync_ok_second, reclose_supervision_condition;
  wire         manual_close_condition, close_output_contact, lockout;
  logic [31:0] rdat;
  int          cyc, n_first, n_close, n_sup, mismatches, num_checks;
  scrs_sync_check #(.QTR_CLKS(QTR)) i_dut (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .angle_diff, .slip_freq, .open_interval_done,
    .sup_extra, .manual_close_input, .sync_ok_first, .sync_ok_second,
    .reclose_supervision_condition, .manual_close_condition,
    .close_output_contact, .lockout, .irq
  );
  scrs_reclose_model i_far (
    .clk, .rst, .start, .close_output_contact, .lockout,
    .open_interval_done, .sup_extra
  );
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= rst ? 0 : cyc + 1;
    n_first <= n_first + int'(sync_ok_first);
    n_close <= n_close + int'(close_output_contact);
    n_sup <= n_sup + int'(reclose_supervision_condition);
  end
  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    chk(pslverr, a > 8'h20 || a[1:0] != 2'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic step(input int a);
    while (cyc % QTR != QTR / 2) @(posedge clk);
    angle_diff <= a[15:0];
    repeat (QTR) @(posedge clk);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
    logic [15:0] rv [7] = '{16'h0003, 16'h05DC, 16'h09C4, 16'h0000,
                            16'h00F0, 16'h0064, 16'h0000};
    for (int i = 0; i < 7; i++) rd(ofs[i], {16'h0000, rv[i]});
    rd(8'h24, 32'h0);
    $display("register reset values done");
  endtask
  task automatic t_static;
    int a [4] = '{1000, -2000, 3000, 2000};
    logic [1:0] e [4] = '{2'h3, 2'h1, 2'h0, 2'h1};
    apb(1'b1, 8'h0C, 32'h4);
    for (int i = 0; i < 4; i++) begin
      step(a[i]);
      chk({sync_ok_first, sync_ok_second},
          e[i]);
    end
    slip_freq <= 16'h00C8;
    step(0);
    step(0);
    chk({sync_ok_first, sync_ok_second}, 2'h0);
    $display("static and slip limit done");
  endtask
  task automatic t_cross;
    int a [7] = '{-4030, -4030, -4030, -1030, 970, 1970, 2970};
    logic [1:0] e [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h1, 2'h0};
    slip_freq <= 16'h0032;
    for (int i = 0; i < 7; i++) begin
      step(a[i]);
      chk({sync_ok_first, sync_ok_second},
          e[i]);
    end
    $display("zero crossing done");
  endtask
  task automatic t_window(input logic [31:0] w, input int base,
                          input logic [3:0] ist);
    int f0, c0, s0;
    apb(1'b1, 8'h10, w);
    apb(1'b1, 8'h20, 32'h8);
    step(base);
    step(base + 100);
    apb(1'b1, 8'h1C, 32'hF);
    f0 = n_first;
    c0 = n_close;
    s0 = n_sup;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (int i = 2; i < 8; i++) step(base + 100 * i);
    chk(n_first - f0, ist[3] ? QTR : 0);
    chk(n_close > c0, ist[3]);
    chk(lockout, !ist[3]);
    chk(irq, ist[3]);
    chk(n_sup - s0, ist[3] ? QTR : 0);
    rd(8'h18, ist[3] ? 32'h40 : 32'h60);
    apb(1'b1, 8'h20, 32'hF);
    rd(8'h1C, {28'h0, ist});
    chk(irq, 1'b1);
    apb(1'b1, 8'h1C, 32'hF);
    rd(8'h1C, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, 8'h00, 32'h7);
    chk(lockout, 1'b0);
    rd(8'h00, 32'h3);
    $display("reclose window done");
  endtask
  task automatic t_manual;
    apb(1'b1, 8'h0C, 32'h0);
    step(2000);
    manual_close_input <= 1'b1;
    step(2000);
    chk({manual_close_condition, close_output_contact},
        2'h3);
    step(3000);
    chk({manual_close_condition, close_output_contact}, 2'h0);
    manual_close_input <= 1'b0;
    apb(1'b1, 8'h00, 32'h2);
    step(1000);
    chk({sync_ok_first, sync_ok_second}, 2'h0);
    apb(1'b1, 8'h00, 32'h3);
    $display("manual close done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_static;
    t_cross;
    t_window(32'h2, -1460, 4'hB);
    t_window(32'h0, -1460, 4'hB);
    t_window(32'h2, -3560, 4'h4);
    t_manual;
    end_of_test;
  end
  initial begin
    #200000;
    mismatches++;
    end_of_test;
  end
endmodule // scrs_sync_check_tb
`default_nettype wire
